// ---- design/dbt_consts.svh ----
`ifndef DBT_CONSTS_SVH
`define DBT_CONSTS_SVH

// register port offsets (8-bit data)
`define DBT_OFF_CMPAH 4'h0
`define DBT_OFF_CMPAL 4'h1
`define DBT_OFF_CMPBH 4'h2
`define DBT_OFF_CMPBL 4'h3
`define DBT_OFF_FIFOH 4'h4
`define DBT_OFF_FIFOL 4'h5
`define DBT_OFF_TRIG  4'h6
`define DBT_OFF_CTRL  4'h7
`define DBT_OFF_STAT  4'h8

// trigger control fields
`define DBT_T_OPSEL 7
`define DBT_T_BEGIN 6
// debug control fields
`define DBT_C_EN    7
`define DBT_C_ARM   6
`define DBT_C_TAG   5
`define DBT_C_BREAKPOINT_ENABLE 4
`define DBT_C_A_DIR_QUALIFY_ENABLE 3
`define DBT_C_RWA   2
`define DBT_C_B_DIR_QUALIFY_ENABLE 1
`define DBT_C_RWB   0
// background status/control fields
`define DBT_S_PERMIT 7
`define DBT_S_BKEN   5
`define DBT_S_FTS    4
`define DBT_S_COMM_CLOCK_SELECT  3

`define DBT_TRIG_RST 8'h00
`define DBT_CTRL_RST 8'h00
`define DBT_CMP_RST  16'h0000
`define DBT_SCR_RST  8'h00
`define DBT_BKPT_RST 16'h0000
`define DBT_DEPTH    4'h8
`define DBT_TRK_DEPTH 3'h4

`endif

// ---- design/dbt_pkg.sv ----
package dbt_pkg;
    typedef enum logic [3:0] {
        DBT_A_ONLY    = 4'h0,
        DBT_A_OR_B    = 4'h1,
        DBT_A_THEN_B  = 4'h2,
        DBT_EVT_B     = 4'h3,
        DBT_A_EVT_B   = 4'h4,
        DBT_A_AND_B   = 4'h5,
        DBT_A_NOT_B   = 4'h6,
        DBT_INSIDE    = 4'h7,
        DBT_OUTSIDE   = 4'h8
    } dbt_mode_e;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  rdata;
        logic [7:0]  wdata;
        logic        rw;
        logic        valid;
        logic        bdc_access;
    } dbt_bus_s;

    typedef struct packed {
        logic fetch;
        logic exec;
        logic flush;
    } dbt_op_s;

    typedef struct packed {
        logic tag;
        logic force_brk;
        logic use_swi;
    } dbt_brk_s;
endpackage : dbt_pkg

// ---- design/dbt_trace_mem.sv ----
`timescale 1ns/1ns
module dbt_trace_mem (
    input  wire logic        clk,
    input  wire logic        we,
    input  wire logic [2:0]  waddr,
    input  wire logic [15:0] wdata,
    input  wire logic [2:0]  raddr,
    output logic      [15:0] rdata
);
    logic [15:0] mem [0:7];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : dbt_trace_mem

// ---- design/dbt_opcode_track.sv ----
`timescale 1ns/1ns
`include "dbt_consts.svh"
module dbt_opcode_track (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic match,
    input  wire logic fetch,
    input  wire logic exec,
    input  wire logic flush,
    output logic      hit
);
    logic [3:0] q_reg;
    logic [3:0] q_next;
    logic [2:0] n_reg;
    logic [2:0] n_next;

    // one tag bit rides with each queued opcode; a flush drops them unexecuted
    always_comb begin
        q_next = q_reg;
        n_next = n_reg;
        if (exec && n_reg != 3'h0) begin
            q_next = {1'b0, q_reg[3:1]};
            n_next = n_reg - 3'h1;
        end
        if (fetch && n_next != `DBT_TRK_DEPTH) begin
            q_next[n_next[1:0]] = match;
            n_next = n_next + 3'h1;
        end
        if (flush) begin
            q_next = 4'h0;
            n_next = 3'h0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_reg <= 4'h0;
            n_reg <= 3'h0;
            hit   <= 1'b0;
        end else begin
            q_reg <= q_next;
            n_reg <= n_next;
            hit   <= exec && n_reg != 3'h0 && q_reg[0];
        end
    end
endmodule : dbt_opcode_track

// ---- design/dbt_top.sv ----
// What this block does
// - four-bit trigger mode field selects one of nine modes.
// - opcode-fetch select routes each comparator through its own opcode tracker.
// - begin bit: store from trigger, or circularly until trigger.
// - writing arm with enable set sets armed flag, clears comparator flags and count.
// - begin run ends when FIFO full; end run ends at trigger.
// - writing zero to arm or enable stops the run at once.
// - FIFO holds change-of-flow addresses, or data bytes in event modes.
// - event-only modes ignore begin bit and always run begin-type.
// - each comparator optionally also requires matching bus direction.
// - breakpoint enable lets the trigger request a tag or force break.
// - A-only matches A; A-or-B matches either comparator.
// - A-then-B fires on a B match after any earlier A match.
// - A-and-B-data needs A address and B low byte data together.
// - A-and-not-B-data needs A address and data unequal to B low.
// - full modes with tag break issue the tag on A match alone.
// - event-only-B stores the data byte at every B match.
// - A-then-event-B stores data at B matches after an A match.
// - inside range fires when A <= address <= B.
// - outside range fires when address < A or address > B.
// - tag break marks the queued opcode; force break finishes the instruction.
// - without background permit a break becomes a software interrupt.
// - permit bit locked while background active; four status bits read-only.
// - trace buffer holds eight sixteen-bit entries.
// - comparators never match during background controller accesses.
// - full modes compare write data when A qualifies writes, else read data.
`timescale 1ns/1ns
`include "dbt_consts.svh"
module dbt_top (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire dbt_pkg::dbt_bus_s cpu,
    input  wire dbt_pkg::dbt_op_s  op,
    input  wire logic              cof_valid,
    input  wire logic [15:0]       cof_addr,
    input  wire logic              reg_sel,
    input  wire logic              reg_we,
    input  wire logic [3:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    output logic      [7:0]        reg_rdata,
    input  wire logic              bdc_ctrl_we,
    input  wire logic [7:0]        bdc_ctrl_wdata,
    input  wire logic              bdc_bkpt_we,
    input  wire logic [15:0]       bdc_bkpt_wdata,
    output logic      [7:0]        bdc_status,
    output logic      [15:0]       bdc_bkpt,
    input  wire logic              bg_active,
    input  wire logic              wait_stop,
    input  wire logic              ws_fail,
    input  wire logic              dv_fail,
    output logic                   comm_clock_select,
    output dbt_pkg::dbt_brk_s      brk
);
    import dbt_pkg::*;

    logic [15:0] cmp_a_reg;
    logic [15:0] cmp_b_reg;
    logic [7:0]  trig_reg;
    logic [7:0]  ctrl_reg;
    logic [7:0]  scr_reg;
    logic [15:0] bkpt_reg;
    logic        armed_reg;
    logic        armed_next;
    logic        af_reg;
    logic        bf_reg;
    logic        started_reg;
    logic [3:0]  cnt_reg;
    logic [3:0]  cnt_next;
    logic [2:0]  wr_ptr_reg;
    logic [15:0] mem_rdata;
    logic [7:0]  rd_mux;
    logic        trig;
    logic [1:0]  hit_raw;
    logic [1:0]  hit_trk;
    dbt_brk_s    brk_next;
    dbt_mode_e   mode;

    assign mode = dbt_mode_e'(trig_reg[3:0]);

    wire dbg_en = ctrl_reg[`DBT_C_EN];
    wire a_dir_qualify_enable  = ctrl_reg[`DBT_C_A_DIR_QUALIFY_ENABLE];
    wire a_dir_match_value    = ctrl_reg[`DBT_C_RWA];
    wire b_dir_qualify_enable  = ctrl_reg[`DBT_C_B_DIR_QUALIFY_ENABLE];
    wire b_dir_match_value    = ctrl_reg[`DBT_C_RWB];
    wire op_sel = trig_reg[`DBT_T_OPSEL];

    // comparators
    wire cmp_ok    = cpu.valid & ~cpu.bdc_access & dbg_en;
    wire a_dir     = ~a_dir_qualify_enable | (cpu.rw == a_dir_match_value);
    wire b_dir     = ~b_dir_qualify_enable | (cpu.rw == b_dir_match_value);
    wire a_hit     = cmp_ok & a_dir & (cpu.addr == cmp_a_reg);
    wire b_hit     = cmp_ok & b_dir & (cpu.addr == cmp_b_reg);
    wire [7:0] bus_byte = (a_dir_qualify_enable & ~a_dir_match_value) ? cpu.wdata : cpu.rdata;
    wire data_eq   = (bus_byte == cmp_b_reg[7:0]);
    wire in_range  = cmp_ok & a_dir & (cpu.addr >= cmp_a_reg)
                     & (cpu.addr <= cmp_b_reg);
    wire out_range = cmp_ok & a_dir & ((cpu.addr < cmp_a_reg)
                     | (cpu.addr > cmp_b_reg));

    assign hit_raw = {b_hit, a_hit};

    // separate trackers so an A and a B tag can be in the queue together
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_trk
            dbt_opcode_track u_trk (
                .clk   (clk),
                .rst_n (rst_n),
                .match (hit_raw[gi]),
                .fetch (op.fetch),
                .exec  (op.exec),
                .flush (op.flush),
                .hit   (hit_trk[gi])
            );
        end
    endgenerate

    wire a_q = op_sel ? hit_trk[0] : hit_raw[0];
    wire b_q = op_sel ? hit_trk[1] : hit_raw[1];

    always_comb begin
        case (mode)
            DBT_A_ONLY:   trig = a_q;
            DBT_A_OR_B:   trig = a_q | b_q;
            DBT_A_THEN_B: trig = b_q & af_reg;
            DBT_EVT_B:    trig = b_q;
            DBT_A_EVT_B:  trig = b_q & af_reg;
            DBT_A_AND_B:  trig = a_q & data_eq;
            DBT_A_NOT_B:  trig = a_q & ~data_eq;
            DBT_INSIDE:   trig = in_range;
            DBT_OUTSIDE:  trig = out_range;
            default:      trig = 1'b0;
        endcase
    end

    wire fire       = armed_reg & trig;
    wire event_mode = (mode == DBT_EVT_B) | (mode == DBT_A_EVT_B);
    wire full_mode  = (mode == DBT_A_AND_B) | (mode == DBT_A_NOT_B);
    wire begin_eff  = trig_reg[`DBT_T_BEGIN] | event_mode;

    // begin type skips the trigger cycle itself, end type keeps it as last entry
    wire store = armed_reg & (event_mode ? fire
                 : cof_valid & (~begin_eff | started_reg));
    wire [15:0] store_data = event_mode ? {8'h00, bus_byte} : cof_addr;

    // register port decode
    wire wr_en    = reg_sel & reg_we;
    wire ctrl_wr  = wr_en & (reg_addr == `DBT_OFF_CTRL);
    wire arm_go   = ctrl_wr & reg_wdata[`DBT_C_ARM] & reg_wdata[`DBT_C_EN];
    wire arm_stop = ctrl_wr & ~arm_go;
    wire pop      = reg_sel & ~reg_we & (reg_addr == `DBT_OFF_FIFOL)
                    & ~armed_reg & (cnt_reg != 4'h0);
    wire end_run  = begin_eff ? (store & (cnt_next == `DBT_DEPTH))
                    : fire;

    always_comb begin
        if (arm_go) begin
            cnt_next = 4'h0;
        end else if (store) begin
            cnt_next = (cnt_reg == `DBT_DEPTH) ? cnt_reg : cnt_reg + 4'h1;
        end else if (pop) begin
            cnt_next = cnt_reg - 4'h1;
        end else begin
            cnt_next = cnt_reg;
        end
    end

    always_comb begin
        if (arm_go) begin
            armed_next = 1'b1;
        end else if (arm_stop | (armed_reg & end_run)) begin
            armed_next = 1'b0;
        end else begin
            armed_next = armed_reg;
        end
    end

    // oldest entry sits count places behind the write pointer
    wire [2:0] rd_ptr = wr_ptr_reg - cnt_reg[2:0];

    dbt_trace_mem u_mem (
        .clk   (clk),
        .we    (store),
        .waddr (wr_ptr_reg),
        .wdata (store_data),
        .raddr (rd_ptr),
        .rdata (mem_rdata)
    );

    // breakpoints
    wire breakpoint_enable    = ctrl_reg[`DBT_C_BREAKPOINT_ENABLE];
    wire tag_sel  = ctrl_reg[`DBT_C_TAG];
    wire tag_src  = full_mode ? (armed_reg & a_q) : fire;
    wire bdc_hit  = scr_reg[`DBT_S_BKEN] & cpu.valid & ~cpu.bdc_access
                    & (cpu.addr == bkpt_reg);
    wire fts      = scr_reg[`DBT_S_FTS];

    assign brk_next.tag       = (breakpoint_enable & tag_sel & tag_src) | (bdc_hit & ~fts);
    assign brk_next.force_brk = (breakpoint_enable & ~tag_sel & fire) | (bdc_hit & fts);
    assign brk_next.use_swi   = ~scr_reg[`DBT_S_PERMIT];

    // permit bit cannot change while background mode is active
    wire permit_new = bg_active ? scr_reg[`DBT_S_PERMIT]
                      : bdc_ctrl_wdata[`DBT_S_PERMIT];
    wire [7:0] scr_wr = {permit_new, 1'b0, bdc_ctrl_wdata[5:3], 3'h0};

    always_comb begin
        case (reg_addr)
            `DBT_OFF_CMPAH: rd_mux = cmp_a_reg[15:8];
            `DBT_OFF_CMPAL: rd_mux = cmp_a_reg[7:0];
            `DBT_OFF_CMPBH: rd_mux = cmp_b_reg[15:8];
            `DBT_OFF_CMPBL: rd_mux = cmp_b_reg[7:0];
            `DBT_OFF_FIFOH: rd_mux = mem_rdata[15:8];
            `DBT_OFF_FIFOL: rd_mux = mem_rdata[7:0];
            `DBT_OFF_TRIG:  rd_mux = trig_reg;
            `DBT_OFF_CTRL:  rd_mux = ctrl_reg;
            `DBT_OFF_STAT:  rd_mux = {af_reg, bf_reg, armed_reg, 1'b0, cnt_reg};
            default:        rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_a_reg <= `DBT_CMP_RST;
            cmp_b_reg <= `DBT_CMP_RST;
            trig_reg  <= `DBT_TRIG_RST;
            ctrl_reg  <= `DBT_CTRL_RST;
        end else if (wr_en) begin
            case (reg_addr)
                `DBT_OFF_CMPAH: cmp_a_reg[15:8] <= reg_wdata;
                `DBT_OFF_CMPAL: cmp_a_reg[7:0]  <= reg_wdata;
                `DBT_OFF_CMPBH: cmp_b_reg[15:8] <= reg_wdata;
                `DBT_OFF_CMPBL: cmp_b_reg[7:0]  <= reg_wdata;
                `DBT_OFF_TRIG:  trig_reg        <= reg_wdata;
                `DBT_OFF_CTRL:  ctrl_reg        <= reg_wdata;
                default:        ;
            endcase
        end
    end

    // a comparator flag set in the same cycle as an arm write is kept
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            armed_reg   <= 1'b0;
            af_reg      <= 1'b0;
            bf_reg      <= 1'b0;
            started_reg <= 1'b0;
            cnt_reg     <= 4'h0;
            wr_ptr_reg  <= 3'h0;
        end else begin
            armed_reg   <= armed_next;
            af_reg      <= (armed_reg & a_q) | (af_reg & ~arm_go);
            bf_reg      <= (armed_reg & b_q) | (bf_reg & ~arm_go);
            started_reg <= (started_reg | (fire & begin_eff)) & ~arm_go;
            cnt_reg     <= cnt_next;
            if (store) begin
                wr_ptr_reg <= wr_ptr_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scr_reg   <= `DBT_SCR_RST;
            bkpt_reg  <= `DBT_BKPT_RST;
            reg_rdata <= 8'h00;
            brk       <= '0;
            bdc_status <= 8'h00;
        end else begin
            if (bdc_ctrl_we) begin
                scr_reg <= scr_wr;
            end
            if (bdc_bkpt_we) begin
                bkpt_reg <= bdc_bkpt_wdata;
            end
            if (reg_sel & ~reg_we) begin
                reg_rdata <= rd_mux;
            end
            brk <= brk_next;
            bdc_status <= {scr_reg[7], bg_active, scr_reg[5:3],
                           wait_stop, ws_fail, dv_fail};
        end
    end

    assign bdc_bkpt          = bkpt_reg;
    assign comm_clock_select = scr_reg[`DBT_S_COMM_CLOCK_SELECT];

    property p_arm_start;
        @(posedge clk) disable iff (!rst_n)
        arm_go |=> armed_reg && cnt_reg == 4'h0;
    endproperty
    a_arm_start: assert property (p_arm_start)
        else $error("arm write did not start a clean run");

    property p_stop;
        @(posedge clk) disable iff (!rst_n)
        arm_stop |=> !armed_reg;
    endproperty
    a_stop: assert property (p_stop)
        else $error("arm or enable cleared but run continues");

    property p_begin_full;
        @(posedge clk) disable iff (!rst_n)
        armed_reg && begin_eff && store && cnt_reg == 4'h7 && !arm_go
            |=> !armed_reg && cnt_reg == 4'h8;
    endproperty
    a_begin_full: assert property (p_begin_full)
        else $error("begin run did not end on full buffer");

    property p_end_trig;
        @(posedge clk) disable iff (!rst_n)
        fire && !begin_eff && !arm_go |=> !armed_reg;
    endproperty
    a_end_trig: assert property (p_end_trig)
        else $error("end run did not stop at trigger");

    property p_event_byte;
        @(posedge clk) disable iff (!rst_n)
        fire && event_mode |-> store && store_data[15:8] == 8'h00;
    endproperty
    a_event_byte: assert property (p_event_byte)
        else $error("event mode trigger not stored as data byte");

    property p_unused_mode;
        @(posedge clk) disable iff (!rst_n)
        trig_reg[3:0] > 4'h8 |-> !trig;
    endproperty
    a_unused_mode: assert property (p_unused_mode)
        else $error("unused mode code produced a trigger");

    property p_bdc_quiet;
        @(posedge clk) disable iff (!rst_n)
        cpu.bdc_access |-> !a_hit && !b_hit && !in_range && !out_range;
    endproperty
    a_bdc_quiet: assert property (p_bdc_quiet)
        else $error("comparator matched during background access");

    property p_permit_lock;
        @(posedge clk) disable iff (!rst_n)
        bdc_ctrl_we && bg_active |=> $stable(scr_reg[7]);
    endproperty
    a_permit_lock: assert property (p_permit_lock)
        else $error("permit bit changed while background active");

    property p_force_brk;
        @(posedge clk) disable iff (!rst_n)
        fire && breakpoint_enable && !tag_sel |=> brk.force_brk && !$past(brk.force_brk, 2)
            || brk.force_brk;
    endproperty
    a_force_brk: assert property (p_force_brk)
        else $error("qualified trigger gave no force request");

    property p_swi;
        @(posedge clk) disable iff (!rst_n)
        !scr_reg[`DBT_S_PERMIT] ##1 !scr_reg[`DBT_S_PERMIT] |-> brk.use_swi;
    endproperty
    a_swi: assert property (p_swi)
        else $error("break not redirected to software interrupt");
endmodule : dbt_top

// ---- verification/dbt_cpu_model.sv ----
`timescale 1ns/1ns
module dbt_cpu_model (
    input  wire logic  clk,
    output dbt_pkg::dbt_bus_s cpu
);
    import dbt_pkg::*;

    initial begin
        cpu = '0;
    end

    // one bus cycle; the unused data bus carries the complement, so picking the wrong
    // bus cannot match, and released lines show the inverse so stale values never match
    task automatic cycle(input logic [15:0] a, input logic r, input logic [7:0] d,
                         input logic b);
        @(negedge clk);
        cpu.addr       = a;
        cpu.rdata      = r ? d : ~d;
        cpu.wdata      = r ? ~d : d;
        cpu.rw         = r;
        cpu.bdc_access = b;
        cpu.valid      = 1'b1;
        @(negedge clk);
        cpu.valid      = 1'b0;
        cpu.bdc_access = 1'b0;
        cpu.addr       = ~a;
        cpu.rdata      = ~cpu.rdata;
        cpu.wdata      = ~cpu.wdata;
    endtask : cycle
endmodule : dbt_cpu_model

// ---- verification/tb.sv ----
`timescale 1ns/1ns
module tb;
    import dbt_pkg::*;
    logic        clk;
    logic        rst_n;
    dbt_bus_s    cpu;
    dbt_op_s     op;
    dbt_brk_s    brk;
    logic        reg_sel, reg_we, bdc_ctrl_we, bdc_bkpt_we;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, bdc_ctrl_wdata, bdc_status, v;
    logic [15:0] bdc_bkpt_wdata, bdc_bkpt, cof_addr;
    logic        cof_valid;
    logic        bg_active, wait_stop, ws_fail, dv_fail, comm_clock_select;
    int          num_errors;
    int          num_checks;

    dbt_cpu_model dbt_cpu_model_inst (.clk(clk), .cpu(cpu));

    dbt_top dbt_top_inst (
        .clk               (clk),
        .rst_n             (rst_n),
        .cpu               (cpu),
        .op                (op),
        .cof_valid         (cof_valid),
        .cof_addr          (cof_addr),
        .reg_sel           (reg_sel),
        .reg_we            (reg_we),
        .reg_addr          (reg_addr),
        .reg_wdata         (reg_wdata),
        .reg_rdata         (reg_rdata),
        .bdc_ctrl_we       (bdc_ctrl_we),
        .bdc_ctrl_wdata    (bdc_ctrl_wdata),
        .bdc_bkpt_we       (bdc_bkpt_we),
        .bdc_bkpt_wdata    (bdc_bkpt_wdata),
        .bdc_status        (bdc_status),
        .bdc_bkpt          (bdc_bkpt),
        .bg_active         (bg_active),
        .wait_stop         (wait_stop),
        .ws_fail           (ws_fail),
        .dv_fail           (dv_fail),
        .comm_clock_select (comm_clock_select),
        .brk               (brk)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_sel   = 1'b1;
        reg_we    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clk);
        reg_sel   = 1'b0;
        reg_we    = 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_sel  = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_sel  = 1'b0;
        @(posedge clk);
        #1 d = reg_rdata;
    endtask : rd

    task automatic bdc_wr(input logic [7:0] d);
        @(negedge clk);
        bdc_ctrl_we    = 1'b1;
        bdc_ctrl_wdata = d;
        @(negedge clk);
        bdc_ctrl_we    = 1'b0;
        repeat (2) @(negedge clk);
    endtask : bdc_wr

    // any break request pulse within three edges counts as seen
    task automatic watch(input logic e);
        logic seen;
        seen = brk.tag | brk.force_brk;
        repeat (3) begin
            @(posedge clk);
            #1 seen = seen | brk.tag | brk.force_brk;
        end
        chk({15'h0000, seen}, {15'h0000, e});
    endtask : watch

    task automatic cof(input logic [15:0] a);
        @(negedge clk);
        cof_valid = 1'b1;
        cof_addr  = a;
        @(negedge clk);
        cof_valid = 1'b0;
    endtask : cof

    task automatic pulse_op(input logic [2:0] v);
        @(negedge clk);
        op = dbt_op_s'(v);
        @(negedge clk);
        op = '0;
    endtask : pulse_op

    // f[0] write cycle, f[1] background access, f[2] comparator A cycle first
    task automatic trig_case(input logic [3:0] m, input logic [7:0] c, input logic [15:0] a,
                             input logic [2:0] f, input logic [7:0] d, input logic e);
        wr(4'h6, {4'h4, m});
        wr(4'h7, c);
        if (f[2]) dbt_cpu_model_inst.cycle(16'h1000, 1'b1, 8'h00, 1'b0);
        dbt_cpu_model_inst.cycle(a, ~f[0], d, f[1]);
        watch(e);
    endtask : trig_case

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    // whole run is a few hundred cycles
    initial begin
        #200000;
        num_errors++;
        close_out();
    end

    initial begin
        num_errors = 0;
        num_checks = 0;
        rst_n = 1'b0;
        op = '0;
        {reg_sel, reg_we, bdc_ctrl_we, bdc_bkpt_we} = 4'h0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        bdc_ctrl_wdata = 8'h00;
        bdc_bkpt_wdata = 16'h0000;
        cof_valid = 1'b0;
        cof_addr = 16'h0000;
        {bg_active, wait_stop, ws_fail, dv_fail} = 4'h0;
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        rd(4'h6, v); chk(v, 8'h00);
        rd(4'h7, v); chk(v, 8'h00);
        wr(4'h8, 8'hff);
        rd(4'h8, v); chk(v, 8'h00);
        wr(4'h9, 8'hff);
        rd(4'h9, v); chk(v, 8'h00);
        chk(brk.use_swi, 1'b1);
        $display("test reset done");

        wr(4'h0, 8'h10);
        wr(4'h1, 8'h00);
        wr(4'h2, 8'h20);
        wr(4'h3, 8'h00);
        // end-type begin bit set on purpose: event mode must still fill and stop
        wr(4'h6, 8'h03);
        wr(4'h7, 8'hc0);
        for (int i = 0; i < 9; i++) begin
            dbt_cpu_model_inst.cycle(16'h2000, 1'b1, 8'h10 + 8'(i), 1'b0);
        end
        rd(4'h8, v); chk(v, 8'h48);
        for (int i = 0; i < 8; i++) begin
            rd(4'h4, v); chk(v, 8'h00);
            rd(4'h5, v); chk(v, 8'h10 + 8'(i));
            repeat (2) @(negedge clk);
        end
        $display("test event capture done");

        wr(4'h6, 8'h40);
        wr(4'h7, 8'hc0);
        rd(4'h8, v); chk(v, 8'h20);
        wr(4'h7, 8'h80);
        rd(4'h8, v); chk(v, 8'h00);
        wr(4'h7, 8'hc0);
        wr(4'h7, 8'h40);
        rd(4'h8, v); chk(v, 8'h00);
        $display("test arm and stop done");

        trig_case(4'h0, 8'hd0, 16'h1000, 3'h0, 8'h00, 1'b1);
        trig_case(4'h0, 8'hd0, 16'h2000, 3'h0, 8'h00, 1'b0);
        trig_case(4'h0, 8'hc0, 16'h1000, 3'h0, 8'h00, 1'b0);
        trig_case(4'h0, 8'hd0, 16'h1000, 3'h2, 8'h00, 1'b0);
        trig_case(4'h0, 8'hd8, 16'h1000, 3'h0, 8'h00, 1'b0);
        trig_case(4'h0, 8'hd8, 16'h1000, 3'h1, 8'h00, 1'b1);
        trig_case(4'h1, 8'hd0, 16'h2000, 3'h0, 8'h00, 1'b1);
        trig_case(4'h2, 8'hd0, 16'h2000, 3'h0, 8'h00, 1'b0);
        trig_case(4'h2, 8'hd0, 16'h2000, 3'h4, 8'h00, 1'b1);
        trig_case(4'h4, 8'hd0, 16'h2000, 3'h0, 8'h00, 1'b0);
        trig_case(4'h4, 8'hd0, 16'h2000, 3'h4, 8'h00, 1'b1);
        trig_case(4'h5, 8'hd0, 16'h1000, 3'h0, 8'h00, 1'b1);
        trig_case(4'h5, 8'hd0, 16'h1000, 3'h0, 8'h55, 1'b0);
        trig_case(4'h5, 8'hd8, 16'h1000, 3'h1, 8'h00, 1'b1);
        trig_case(4'h5, 8'hf0, 16'h1000, 3'h0, 8'h55, 1'b1);
        trig_case(4'h6, 8'hd0, 16'h1000, 3'h0, 8'h55, 1'b1);
        trig_case(4'h6, 8'hd0, 16'h1000, 3'h0, 8'h00, 1'b0);
        trig_case(4'h7, 8'hd0, 16'h1800, 3'h0, 8'h00, 1'b1);
        trig_case(4'h7, 8'hd0, 16'h2001, 3'h0, 8'h00, 1'b0);
        trig_case(4'h8, 8'hd0, 16'h2001, 3'h0, 8'h00, 1'b1);
        trig_case(4'h8, 8'hd0, 16'h1800, 3'h0, 8'h00, 1'b0);
        trig_case(4'h9, 8'hd0, 16'h1000, 3'h0, 8'h00, 1'b0);
        trig_case(4'hf, 8'hd0, 16'h1000, 3'h0, 8'h00, 1'b0);
        $display("test trigger modes done");

        // end type: entries before the trigger kept, nothing after it
        wr(4'h6, 8'h00);
        wr(4'h7, 8'hc0);
        for (int i = 0; i < 3; i++) cof(16'ha000 + 16'(i));
        dbt_cpu_model_inst.cycle(16'h1000, 1'b1, 8'h00, 1'b0);
        cof(16'ha0ff);
        rd(4'h8, v); chk(v, 8'h83);
        for (int i = 0; i < 3; i++) begin
            rd(4'h4, v); chk(v, 8'ha0);
            rd(4'h5, v); chk(v, 8'(i));
            repeat (2) @(negedge clk);
        end
        // begin type: only entries after the trigger kept, run goes on
        wr(4'h6, 8'h40);
        wr(4'h7, 8'hc0);
        cof(16'hb000);
        dbt_cpu_model_inst.cycle(16'h1000, 1'b1, 8'h00, 1'b0);
        cof(16'hb001);
        cof(16'hb002);
        rd(4'h8, v); chk(v, 8'ha2);
        $display("test trace capture done");

        // opcode tracking: a flushed tag never triggers, an executed one does
        wr(4'h6, 8'h80);
        wr(4'h7, 8'hd0);
        for (int k = 0; k < 2; k++) begin
            fork
                dbt_cpu_model_inst.cycle(16'h1000, 1'b1, 8'h00, 1'b0);
                pulse_op(3'h4);
            join
            watch(1'b0);
            if (k == 0) pulse_op(3'h1);
            pulse_op(3'h2);
            watch(k[0]);
        end
        $display("test opcode tracking done");

        @(negedge clk);
        wait_stop = 1'b1;
        dv_fail   = 1'b1;
        bdc_wr(8'h88);
        chk(bdc_status, 8'h8d);
        chk(brk.use_swi, 1'b0);
        chk(comm_clock_select, 1'b1);
        bg_active = 1'b1;
        bdc_wr(8'h00);
        chk(bdc_status, 8'hc5);
        bdc_wr(8'h47);
        chk(bdc_status, 8'hc5);
        @(negedge clk);
        bdc_bkpt_we    = 1'b1;
        bdc_bkpt_wdata = 16'hbeef;
        @(negedge clk);
        bdc_bkpt_we    = 1'b0;
        @(negedge clk);
        chk(bdc_bkpt, 16'hbeef);
        $display("test background control done");
        close_out();
    end
endmodule : tb
